// [logic/request_flag_cell.sv]
// One timer interrupt request flag with set-over-clear priority
module request_flag_cell (
  input wire logic mclk,
  input wire logic rst,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } cell_state_t;

  cell_state_t cell_ff;
  cell_state_t nxt_cell;

  always_comb begin
    nxt_cell = cell_ff;
    if (set_pulse) begin
      nxt_cell.flag = 1'b1;
    end else if (clr_pulse) begin
      nxt_cell.flag = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cell_ff.flag <= flag_skip_pkg::FLAG_RESET;
    end else begin
      cell_ff <= nxt_cell;
    end
  end

  assign flag = cell_ff.flag;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  set_wins_a: assert property (set_pulse |=> flag)
    else $error("flag lost a set pulse");
  clear_works_a: assert property (clr_pulse && !set_pulse |=> !flag)
    else $error("flag not cleared");
endmodule : request_flag_cell

// [logic/timer_flag_skip_test.sv]
// Executes the two timer request flag skip-test instructions
// Notes on behaviour
// [RULE1] Timer A test with its enable at 0 skips next word when flag is 1.
// [RULE2] A skip caused by the timer A flag clears that flag in the same instruction.
// [RULE3] Timer A test with its enable at 1 is a no-operation, flag untouched.
// [RULE4] Timer A enable sits at bit 2 of the first interrupt control register.
// [RULE5] Timer B test with its enable at 0 skips next word when flag is 1.
// [RULE6] Timer B test with flag at 0 lets the next word execute normally.
// [RULE7] Each test is one word, one cycle; a skipped word acts as no-operation.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
module timer_flag_skip_test (
  input wire logic mclk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic timer_a_set,
  input wire logic timer_b_set,
  input wire logic [3:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  output logic instr_suppress,
  output logic skip_pending,
  output logic timer_a_request_flag,
  output logic timer_b_request_flag
);
  typedef struct packed {
    logic [3:0] irq_control_first;
    logic skip;
    logic [3:0] rdata;
  } core_state_t;

  core_state_t state_ff;
  core_state_t nxt_state;

  logic [1:0] flags;
  logic [1:0] set_in;
  logic [1:0] clr_in;
  logic [1:0] enables;
  logic [1:0] tests;
  logic executing;
  logic [1:0] take_skip;

  function automatic logic is_test(input logic [9:0] word, input int unsigned which);
    logic [9:0] op;
    op = (which == 0) ? flag_skip_pkg::OP_SKIP_TIMER_A : flag_skip_pkg::OP_SKIP_TIMER_B;
    return word == op;
  endfunction : is_test

  // Skipped word still consumes its cycle but has no effect
  assign instr_suppress = instr_valid & state_ff.skip; // RULE7
  assign executing = instr_valid & ~state_ff.skip; // RULE7
  assign enables[0] = state_ff.irq_control_first[flag_skip_pkg::TIMER_A_EN_BIT]; // RULE4
  assign enables[1] = state_ff.irq_control_first[flag_skip_pkg::TIMER_B_EN_BIT];
  assign set_in = {timer_b_set, timer_a_set};

  genvar gi;
  generate
    for (gi = 0; gi < flag_skip_pkg::NUM_TIMERS; gi++) begin : g_flag
      assign tests[gi] = executing & is_test(instr_word, gi);
      // Enable set: plain no-operation, flag left alone
      assign take_skip[gi] = tests[gi] & ~enables[gi] & flags[gi]; // RULE1 RULE3 RULE5 RULE6
      assign clr_in[gi] = take_skip[gi]; // RULE2
      request_flag_cell u_cell (
        .mclk(mclk),
        .rst(rst),
        .set_pulse(set_in[gi]),
        .clr_pulse(clr_in[gi]),
        .flag(flags[gi])
      );
    end
  endgenerate

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = 4'h0;
    // Skip marks the next valid word; it is consumed by that word
    if (|take_skip) begin
      nxt_state.skip = 1'b1; // RULE1 RULE5
    end else if (instr_valid) begin
      nxt_state.skip = 1'b0; // RULE6 RULE7
    end
    if (reg_wr) begin
      if (reg_addr == flag_skip_pkg::OFS_IRQ_CONTROL_FIRST) begin
        nxt_state.irq_control_first = reg_wdata; // RULE4
      end
    end
    if (reg_rd) begin
      if (reg_addr == flag_skip_pkg::OFS_IRQ_CONTROL_FIRST) begin
        nxt_state.rdata = state_ff.irq_control_first;
      end else if (reg_addr == flag_skip_pkg::OFS_FLAG_STATUS) begin
        nxt_state.rdata = {2'h0, flags[flag_skip_pkg::FLAG_B_BIT],
                           flags[flag_skip_pkg::FLAG_A_BIT]};
      end else if (reg_addr == flag_skip_pkg::OFS_SKIP_STATUS) begin
        nxt_state.rdata = {3'h0, state_ff.skip};
      end else begin
        nxt_state.rdata = 4'h0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff.irq_control_first <= flag_skip_pkg::IRQ_CONTROL_RESET;
      state_ff.skip <= 1'b0;
      state_ff.rdata <= 4'h0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign skip_pending = state_ff.skip;
  assign timer_a_request_flag = flags[0];
  assign timer_b_request_flag = flags[1];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence a_test_live;
    executing && instr_word == flag_skip_pkg::OP_SKIP_TIMER_A;
  endsequence
  sequence b_test_live;
    executing && instr_word == flag_skip_pkg::OP_SKIP_TIMER_B;
  endsequence
  sequence skip_consumed;
    instr_valid ##0 instr_suppress ##1 (!skip_pending || $past(instr_valid));
  endsequence

  skip_a_taken_a: assert property ( // RULE1
    a_test_live and (!state_ff.irq_control_first[2] && flags[0]) |=> skip_pending)
    else $error("timer A test did not skip");
  clear_a_flag_a: assert property ( // RULE2
    a_test_live and (!state_ff.irq_control_first[2] && flags[0] && !timer_a_set)
    |=> !timer_a_request_flag && skip_pending)
    else $error("timer A flag not cleared on skip");
  nop_a_test_a: assert property ( // RULE3
    a_test_live and (state_ff.irq_control_first[2] && !timer_a_set)
    |=> !skip_pending && timer_a_request_flag == $past(timer_a_request_flag))
    else $error("timer A test not a no-operation");
  enable_bit_a: assert property ( // RULE4
    reg_wr && reg_addr == flag_skip_pkg::OFS_IRQ_CONTROL_FIRST
    |=> enables[0] == $past(reg_wdata[2]))
    else $error("timer A enable not at bit 2");
  skip_b_taken_a: assert property ( // RULE5
    b_test_live and (!state_ff.irq_control_first[3] && flags[1])
    |=> skip_pending && !timer_b_request_flag || $past(timer_b_set))
    else $error("timer B test did not skip");
  no_skip_b_a: assert property ( // RULE6
    b_test_live and (!flags[1]) |=> !skip_pending)
    else $error("timer B test skipped with flag clear");
  skip_once_a: assert property ( // RULE7
    skip_pending && instr_valid && !(|take_skip) |-> skip_consumed ##0 !skip_pending)
    else $error("skipped word not suppressed once");
  read_data_a: assert property (
    reg_rd && reg_addr == flag_skip_pkg::OFS_FLAG_STATUS
    |=> reg_rdata == {2'h0, $past(flags)})
    else $error("flag status read wrong");

  // Single-cycle pieces shared by the checks below
  sequence a_skip_hit;
    a_test_live ##0 (!enables[0] && flags[0]);
  endsequence

  sequence b_skip_hit;
    b_test_live ##0 (!enables[1] && flags[1]);
  endsequence

  sequence word_dropped;
    instr_valid ##0 skip_pending;
  endsequence

  sequence ctrl_write;
    reg_wr && reg_addr == flag_skip_pkg::OFS_IRQ_CONTROL_FIRST;
  endsequence

  a_skip_clears_a: assert property ( // RULE2
    a_skip_hit
    |=> !timer_a_request_flag || $past(timer_a_set))
    else $error("timer A flag survived its skip");

  b_skip_clears_a: assert property ( // RULE5
    b_skip_hit
    |=> !timer_b_request_flag || $past(timer_b_set))
    else $error("timer B flag survived its skip");

  a_skip_pending_a: assert property ( // RULE1
    a_skip_hit
    |=> skip_pending)
    else $error("timer A hit left no pending skip");

  b_skip_pending_a: assert property ( // RULE5
    b_skip_hit
    |=> skip_pending)
    else $error("timer B hit left no pending skip");

  a_clear_noskip_a: assert property ( // RULE1
    a_test_live ##0 !flags[0]
    |=> !skip_pending)
    else $error("timer A test skipped with flag clear");

  b_enable_nop_a: assert property ( // RULE5
    b_test_live ##0 enables[1]
    |=> !skip_pending)
    else $error("timer B test skipped while enabled");

  b_nop_keeps_a: assert property ( // RULE5
    b_test_live ##0 (enables[1] && flags[1])
    |=> timer_b_request_flag)
    else $error("timer B no-operation cleared the flag");

  a_nop_keeps_a: assert property ( // RULE3
    a_test_live ##0 (enables[0] && flags[0])
    |=> timer_a_request_flag)
    else $error("timer A no-operation cleared the flag");

  dropped_keeps_a_a: assert property ( // RULE7
    word_dropped ##0 flags[0]
    |=> timer_a_request_flag)
    else $error("skipped word cleared timer A flag");

  dropped_keeps_b_a: assert property ( // RULE7
    word_dropped ##0 flags[1]
    |=> timer_b_request_flag)
    else $error("skipped word cleared timer B flag");

  dropped_no_skip_a: assert property ( // RULE7
    word_dropped
    |=> !skip_pending)
    else $error("skipped word started a new skip");

  skip_hold_a: assert property ( // RULE7
    skip_pending && !instr_valid
    |=> skip_pending)
    else $error("pending skip lost without a word");

  idle_no_skip_a: assert property ( // RULE6
    !skip_pending && !instr_valid
    |=> !skip_pending)
    else $error("skip appeared without a word");

  other_word_a: assert property ( // RULE6
    executing && instr_word != flag_skip_pkg::OP_SKIP_TIMER_A
    && instr_word != flag_skip_pkg::OP_SKIP_TIMER_B |=> !skip_pending)
    else $error("ordinary word caused a skip");

  a_only_test_a: assert property ( // RULE2
    !tests[0] && flags[0]
    |=> timer_a_request_flag)
    else $error("timer A flag cleared without a test");

  b_only_test_a: assert property ( // RULE5
    !tests[1] && flags[1]
    |=> timer_b_request_flag)
    else $error("timer B flag cleared without a test");

  a_set_raises_a: assert property ( // RULE1
    timer_a_set
    |=> timer_a_request_flag)
    else $error("timer A set pulse lost");

  b_set_raises_a: assert property ( // RULE5
    timer_b_set
    |=> timer_b_request_flag)
    else $error("timer B set pulse lost");

  set_beats_clear_a: assert property ( // RULE2
    a_skip_hit ##0 timer_a_set
    |=> timer_a_request_flag && skip_pending)
    else $error("set and skip clash handled wrong");

  a_flag_quiet_a: assert property ( // RULE2
    !flags[0] && !timer_a_set
    |=> !timer_a_request_flag)
    else $error("timer A flag rose by itself");

  b_flag_quiet_a: assert property ( // RULE6
    !flags[1] && !timer_b_set
    |=> !timer_b_request_flag)
    else $error("timer B flag rose by itself");

  ctrl_holds_a: assert property ( // RULE4
    !(reg_wr && reg_addr == flag_skip_pkg::OFS_IRQ_CONTROL_FIRST)
    |=> $stable(state_ff.irq_control_first))
    else $error("control register changed unasked");

  ctrl_write_a: assert property ( // RULE4
    ctrl_write
    |=> state_ff.irq_control_first == $past(reg_wdata))
    else $error("control register write lost");

  b_enable_bit_a: assert property ( // RULE5
    ctrl_write
    |=> enables[1] == $past(reg_wdata[flag_skip_pkg::TIMER_B_EN_BIT]))
    else $error("timer B enable at wrong bit");

  read_ctrl_a: assert property ( // RULE4
    reg_rd && reg_addr == flag_skip_pkg::OFS_IRQ_CONTROL_FIRST
    |=> reg_rdata == $past(state_ff.irq_control_first))
    else $error("control register read wrong");

  read_skip_a: assert property ( // RULE7
    reg_rd && reg_addr == flag_skip_pkg::OFS_SKIP_STATUS
    |=> reg_rdata == {3'h0, $past(skip_pending)})
    else $error("skip status read wrong");

  read_idle_a: assert property ( // RULE4
    !reg_rd
    |=> reg_rdata == 4'h0)
    else $error("read data not zero when idle");

  read_unmapped_a: assert property ( // RULE4
    reg_rd && reg_addr > flag_skip_pkg::OFS_SKIP_STATUS
    |=> reg_rdata == 4'h0)
    else $error("unmapped read not zero");
endmodule : timer_flag_skip_test

// [shared/flag_skip_pkg.sv]
// Constants for the timer flag skip-test block
package flag_skip_pkg;
  localparam int WORD_W = 10;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 4;
  localparam logic [9:0] OP_SKIP_TIMER_A = 10'h280;
  localparam logic [9:0] OP_SKIP_TIMER_B = 10'h281;
  localparam logic [3:0] OFS_IRQ_CONTROL_FIRST = 4'h0;
  localparam logic [3:0] OFS_FLAG_STATUS = 4'h1;
  localparam logic [3:0] OFS_SKIP_STATUS = 4'h2;
  localparam int TIMER_A_EN_BIT = 2;
  localparam int TIMER_B_EN_BIT = 3;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_B_BIT = 1;
  localparam logic [3:0] IRQ_CONTROL_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;
  localparam int NUM_TIMERS = 2;
endpackage : flag_skip_pkg

// [tb/sequencer_model.sv]
// Behavioural program sequencer presenting executed instruction words
module sequencer_model (
  input wire logic mclk,
  input wire logic issue,
  input wire logic [9:0] word,
  output logic instr_valid,
  output logic [9:0] instr_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] last_ff = 10'h000;
  always_ff @(posedge mclk) if (issue) last_ff <= word;
  assign instr_valid = issue;
  // Idle bus shows inverted last word
  assign instr_word = issue ? word : ~last_ff;
endmodule : sequencer_model

// [tb/timer_flag_skip_test_tb_top.sv]
// Testbench for the timer flag skip-test block
module timer_flag_skip_test_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic issue = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [9:0] word = 10'h000;
  logic [1:0] tset = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [3:0] wdata = 4'h0;
  logic [3:0] rdata;
  logic sup, skip, fa, fb, iv;
  logic [9:0] iw;
  int miscompares = 0;
  int checks_done = 0;
  localparam logic [9:0] OA = flag_skip_pkg::OP_SKIP_TIMER_A;
  localparam logic [9:0] OB = flag_skip_pkg::OP_SKIP_TIMER_B;
  localparam logic [3:0] CTL = flag_skip_pkg::OFS_IRQ_CONTROL_FIRST;
  initial forever #4 mclk = ~mclk;
  sequencer_model u_seq (.mclk(mclk), .issue(issue), .word(word), .instr_valid(iv),
    .instr_word(iw));
  timer_flag_skip_test u_dut (.mclk(mclk), .rst(rst), .instr_valid(iv), .instr_word(iw),
    .timer_a_set(tset[0]), .timer_b_set(tset[1]), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .instr_suppress(sup),
    .skip_pending(skip), .timer_a_request_flag(fa), .timer_b_request_flag(fb));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    checks_done++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      miscompares++;
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [3:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [3:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_reg
  task automatic raise(input logic [1:0] v);
    @(posedge mclk);
    tset <= v;
    @(posedge mclk);
    tset <= 2'h0;
  endtask : raise
  // Expected state is {0, skip_pending, flag b, flag a}
  task automatic exec(input logic [9:0] w, input logic s, input logic [3:0] e);
    @(posedge mclk);
    issue <= 1'b1;
    word <= w;
    #1;
    chk({3'h0, sup}, {3'h0, s});
    @(posedge mclk);
    issue <= 1'b0;
    #1;
    chk({1'b0, skip, fb, fa}, e);
  endtask : exec
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(CTL, flag_skip_pkg::IRQ_CONTROL_RESET);
    rd_reg(4'hf, 4'h0);
    raise(2'h3);
    exec(OA, 1'b0, 4'h6);
    exec(OB, 1'b1, 4'h2);
    $display("test timer a skip done");
    wr_reg(CTL, 4'h4);
    rd_reg(CTL, 4'h4);
    raise(2'h1);
    exec(OA, 1'b0, 4'h3);
    wr_reg(CTL, 4'h8);
    exec(OA, 1'b0, 4'h6);
    exec(10'h000, 1'b1, 4'h2);
    exec(OB, 1'b0, 4'h2);
    $display("test enable gating done");
    wr_reg(CTL, 4'h0);
    wr_reg(flag_skip_pkg::OFS_FLAG_STATUS, 4'h0);
    rd_reg(flag_skip_pkg::OFS_FLAG_STATUS, 4'h2);
    exec(OB, 1'b0, 4'h4);
    exec(10'h001, 1'b1, 4'h0);
    exec(OB, 1'b0, 4'h0);
    rd_reg(flag_skip_pkg::OFS_SKIP_STATUS, 4'h0);
    $display("test timer b skip done");
    finish_test();
  end
endmodule : timer_flag_skip_test_tb_top
